/* File: test/fwp_host.sv */
// SPI host model that frames instructions for the protection block
`timescale 1ns/1ps
`default_nettype none
module fwp_host (
   output logic link_sck,
   output logic cs_n_pin,
   output logic si_pin
);
   initial
   begin
      link_sck = 1'b0;
      cs_n_pin = 1'b1;
      si_pin = 1'b0;
   end
   // Gap first, so the caller sees the answer; the clock runs only in frames
   task automatic send(input logic [39:0] f, input int n);
      #400;
      cs_n_pin = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         si_pin = f[39-i];
         #7.5 link_sck = 1'b1;
         #7.5 link_sck = 1'b0;
      end
      #7.5 cs_n_pin = 1'b1;
      si_pin = ~si_pin;
   endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the flash write-protect block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic core_clk, rst_n, wp_n, hold_n, ded_n, strap;
   wire logic sck, cs_n, si;
   fwp_pkg::fwp_status_s st;
   fwp_pkg::fwp_function_s fn;
   fwp_pkg::fwp_op_e kind;
   logic start, done, refused, quad, hold_act, dev_rst;
   logic [23:0] addr;
   logic [7:0] data;
   int n_errors = 0;
   int n_tests = 0;
   fwp_host host (.link_sck(sck), .cs_n_pin(cs_n), .si_pin(si));
   fwp_core uut (.core_clk(core_clk), .rst_n(rst_n), .link_sck(sck), .cs_n_pin(cs_n),
      .si_pin(si), .wp_n_pin(wp_n), .hold_rst_n_pin(hold_n), .dedicated_rst_n_pin(ded_n),
      .rst_dis_strap(strap), .status_q(st), .function_q(fn), .op_start(start),
      .op_kind(kind), .op_addr(addr), .op_data(data), .op_done(done), .refused(refused),
      .quad_io_mode(quad), .hold_active(hold_act), .device_reset(dev_rst));
   // ==========================================
   // Shared tasks
   task automatic test_done();
      $display("Checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_for(input logic dn);
      int k;
      for (k = 0; k < 40 && (dn ? done : (start | refused)) !== 1'b1; k++)
         @(negedge core_clk);
      if (k == 40)
      begin
         n_errors++;
         test_done();
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      host.send({op, 32'h0000_0000}, 8);
      repeat (6) @(negedge core_clk);
   endtask
   // Frame is left aligned; an accepted frame must raise op_start and a refused one refused
   task automatic xfer(input logic [39:0] f, input int n, input logic wr, input logic acc,
      input logic dn);
      if (wr)
         cmd(fwp_pkg::WRITE_ENABLE_INSTR);
      host.send(f, n);
      wait_for(1'b0);
      chk("op_start", acc, start);
      chk("refused", !acc, refused);
      if (acc && dn)
         wait_for(1'b1);
   endtask
   function automatic logic [39:0] pp(input logic [7:0] op, input logic [5:0] b);
      return {op, 2'h0, b, 16'h0100, 8'ha5};
   endfunction
   function automatic logic prot(input int c, input int b);
      return c inside {7, 8} || (c >= 1 && c <= 6 && b >= 64 - (1 << (c - 1)))
         || (c >= 9 && c <= 14 && b < (1 << (14 - c)));
   endfunction
   // ==========================================
   // Scenarios
   task automatic t_prot();
      int bl[4] = '{0, 31, 32, 63};
      for (int c = 0; c < 16; c++)
      begin
         xfer({fwp_pkg::STATUS_WRITE_INSTR, 2'h0, 4'(c), 26'h0}, 16, 1, 1, 1);
         chk("status", {2'h0, 4'(c), 2'h0}, st);
         foreach (bl[i])
            xfer(pp(fwp_pkg::PAGE_PROGRAM_INSTR, 6'(bl[i])), 40, 1, !prot(c, bl[i]), 1);
      end
      xfer({fwp_pkg::CHIP_ERASE_INSTR_A, 32'h0}, 8, 1, 0, 1);
      cmd(fwp_pkg::WRITE_DISABLE_INSTR);
      chk("latch", 8'h3c, st);
      xfer({fwp_pkg::STATUS_WRITE_INSTR, 32'h0}, 16, 1, 1, 1);
   endtask
   task automatic t_codes();
      logic [7:0] ops[16] = '{8'h02, 8'h32, 8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60,
         8'h01, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h15};
      for (int w = 0; w < 2; w++)
         foreach (ops[i])
            xfer({ops[i], 32'h0}, 40, w[0], w[0], 1);
   endtask
   task automatic t_susp(input logic [39:0] f, input int idx, input fwp_pkg::fwp_op_e k);
      xfer(f, 40, 1, 1, 0);
      chk("op_kind", k, kind);
      chk("op_addr", 8'h05, addr[23:16]);
      chk("op_data", k == fwp_pkg::OP_PROG ? 8'ha5 : 8'h05, data);
      cmd(fwp_pkg::SUSPEND_INSTR);
      chk("suspended", 8'h01, fn[idx]);
      // Only a short count is left after resume, so watch for the end straight away
      host.send({fwp_pkg::RESUME_INSTR, 32'h0}, 8);
      wait_for(1'b1);
      chk("resumed", 8'h00, fn[idx]);
   endtask
   task automatic t_lock();
      xfer({fwp_pkg::STATUS_WRITE_INSTR, 8'h80, 24'h0}, 16, 1, 1, 1);
      wp_n = 1'b0;
      xfer({fwp_pkg::STATUS_WRITE_INSTR, 8'h04, 24'h0}, 16, 1, 0, 1);
      chk("locked", 8'h82, st);
      wp_n = 1'b1;
      xfer({fwp_pkg::STATUS_WRITE_INSTR, 8'h40, 24'h0}, 16, 1, 1, 1);
      chk("quad", 8'h01, quad);
      xfer({fwp_pkg::STATUS_WRITE_INSTR, 32'h0}, 16, 1, 1, 1);
   endtask
   task automatic t_func();
      ded_n = 1'b0;
      hold_n = 1'b0;
      repeat (6) @(negedge core_clk);
      chk("dedicated on", 8'h01, dev_rst);
      chk("hold", 8'h01, hold_act);
      ded_n = 1'b1;
      hold_n = 1'b1;
      xfer({fwp_pkg::FUNCTION_WRITE_INSTR, 8'h11, 24'h0}, 16, 1, 1, 1);
      xfer({fwp_pkg::FUNCTION_WRITE_INSTR, 8'h0e, 24'h0}, 16, 1, 1, 1);
      chk("function", 8'h11, fn);
      xfer(pp(fwp_pkg::INFO_ROW_PROGRAM_INSTR, 6'h0) & ~40'h1_0000, 40, 1, 0, 1);
      xfer(pp(fwp_pkg::INFO_ROW_PROGRAM_INSTR, 6'h0), 40, 1, 1, 1);
      ded_n = 1'b0;
      repeat (6) @(negedge core_clk);
      chk("dedicated", 8'h00, dev_rst);
      ded_n = 1'b1;
      hold_n = 1'b0;
      repeat (6) @(negedge core_clk);
      chk("shared", 8'h01, dev_rst);
      hold_n = 1'b1;
   endtask
   task automatic t_strap();
      rst_n = 1'b0;
      strap = 1'b1;
      repeat (20) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (6) @(negedge core_clk);
      chk("strap default", 8'h01, fn);
      chk("strap status", 8'h00, st);
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial
   begin
      rst_n = 1'b0;
      wp_n = 1'b1;
      hold_n = 1'b1;
      ded_n = 1'b1;
      strap = 1'b0;
      repeat (20) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (6) @(negedge core_clk);
      chk("status reset", 8'h00, st);
      chk("function reset", 8'h00, fn);
      t_prot();
      t_codes();
      t_susp(pp(fwp_pkg::PAGE_PROGRAM_INSTR, 6'h05), 2, fwp_pkg::OP_PROG);
      t_susp(pp(fwp_pkg::SECTOR_ERASE_INSTR_B, 6'h05), 3, fwp_pkg::OP_ERASE);
      t_lock();
      t_func();
      t_strap();
      test_done();
   end
endmodule
`default_nettype wire

/* File: verilog/fwp_core.sv */
// Write protection, status and function registers of a serial flash
`timescale 1ns/1ps
`default_nettype none
module fwp_core (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic link_sck,
   input wire logic cs_n_pin,
   input wire logic si_pin,
   input wire logic wp_n_pin,
   input wire logic hold_rst_n_pin,
   input wire logic dedicated_rst_n_pin,
   input wire logic rst_dis_strap,
   output fwp_pkg::fwp_status_s status_q,
   output fwp_pkg::fwp_function_s function_q,
   output logic op_start,
   output fwp_pkg::fwp_op_e op_kind,
   output logic [23:0] op_addr,
   output logic [7:0] op_data,
   output logic op_done,
   output logic refused,
   output logic quad_io_mode,
   output logic hold_active,
   output logic device_reset
);
   // ==========================================================
   // Link side: serial capture on the link clock
   logic link_rst_n;
   logic [5:0] bit_cnt_ff;
   logic [6:0] shift_ff;
   logic [23:0] addr_sh_ff;
   fwp_pkg::fwp_frame_s link_frame_ff;

   // Chip enable high ends the frame without needing a further clock edge
   assign link_rst_n = rst_n & ~cs_n_pin;

   always_ff @(posedge link_sck or negedge link_rst_n)
   begin
      if (!link_rst_n)
         bit_cnt_ff <= 6'h00;
      else if (bit_cnt_ff != fwp_pkg::LEN_WITH_DATA)
         bit_cnt_ff <= bit_cnt_ff + 6'h01;
   end

   always_ff @(posedge link_sck or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_ff <= 7'h00;
         addr_sh_ff <= 24'h00_0000;
         link_frame_ff <= '0;
      end
      else
      begin
         shift_ff <= {shift_ff[5:0], si_pin};
         if (bit_cnt_ff != fwp_pkg::LEN_WITH_DATA)
            link_frame_ff.len <= bit_cnt_ff + 6'h01;
         if (bit_cnt_ff == fwp_pkg::CNT_OPCODE_LAST)
            link_frame_ff.opcode <= {shift_ff, si_pin};
         if (bit_cnt_ff == fwp_pkg::CNT_BYTE1_LAST)
            link_frame_ff.byte1 <= {shift_ff, si_pin};
         if (bit_cnt_ff > fwp_pkg::CNT_OPCODE_LAST && bit_cnt_ff <= fwp_pkg::CNT_ADDR_LAST)
            addr_sh_ff <= {addr_sh_ff[22:0], si_pin};
         if (bit_cnt_ff == fwp_pkg::CNT_ADDR_LAST)
            link_frame_ff.addr <= {addr_sh_ff[22:0], si_pin};
         if (bit_cnt_ff == fwp_pkg::CNT_DATA_LAST)
            link_frame_ff.data <= {shift_ff, si_pin};
      end
   end

   // ==========================================================
   // Pin synchronisers and frame end detect
   logic [4:0] pins_sync;
   logic cs_sync, wp_sync, hold_sync, drst_sync, strap_sync;
   logic cs_sync_d_ff;
   logic frame_done;

   fwp_sync #(.WIDTH(5)) u_pin_sync (
      .clk(core_clk),
      .rst_n(rst_n),
      .async_in({cs_n_pin, wp_n_pin, hold_rst_n_pin, dedicated_rst_n_pin, rst_dis_strap}),
      .sync_out(pins_sync)
   );

   assign {cs_sync, wp_sync, hold_sync, drst_sync, strap_sync} = pins_sync;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         cs_sync_d_ff <= 1'b1;
      else
         cs_sync_d_ff <= cs_sync;
   end

   // Link frame fields are static once chip enable has been high two core cycles
   assign frame_done = cs_sync & ~cs_sync_d_ff;

   // ==========================================================
   // Block-protect decode over 64 blocks
   function automatic logic prot_hit(input logic [3:0] bp, input logic [5:0] blk);
      logic hit;
      hit = 1'b0;
      unique case (bp)
         4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6:
            hit = (~blk) <= (fwp_pkg::LAST_BLOCK >> (4'h7 - bp));
         4'h7, 4'h8:
            hit = 1'b1;
         4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he:
            hit = blk <= (fwp_pkg::LAST_BLOCK >> (bp - 4'h8));
         4'h0, 4'hf:
            hit = 1'b0;
      endcase
      return hit;
   endfunction

   // ==========================================================
   // Instruction decode and permission
   fwp_pkg::fwp_status_s sr_ff;
   fwp_pkg::fwp_function_s fr_ff;
   fwp_pkg::fwp_state_e st_ff;
   fwp_pkg::fwp_op_e kind_ff;
   fwp_pkg::fwp_op_e nxt_kind;
   fwp_pkg::fwp_frame_s fr_in;
   logic len_ok, blocked, sr_locked, go_write, accept, refuse;
   logic do_write_enable_instr, do_write_disable_instr, do_susp, do_resume;
   logic [7:0] busy_cnt_ff;
   logic finish;

   assign fr_in = link_frame_ff;
   // Write-protect pin is a data line in quad mode, so it cannot lock then
   assign sr_locked = sr_ff.status_write_disable & ~wp_sync & ~sr_ff.quad_enable;

   always_comb
   begin
      nxt_kind = fwp_pkg::OP_NONE;
      len_ok = 1'b0;
      blocked = 1'b0;
      do_write_enable_instr = 1'b0;
      do_write_disable_instr = 1'b0;
      do_susp = 1'b0;
      do_resume = 1'b0;
      unique case (fr_in.opcode)
         fwp_pkg::WRITE_ENABLE_INSTR:
            do_write_enable_instr = 1'b1;
         fwp_pkg::WRITE_DISABLE_INSTR:
            do_write_disable_instr = 1'b1;
         fwp_pkg::PAGE_PROGRAM_INSTR, fwp_pkg::QUAD_PAGE_PROGRAM_INSTR_A,
         fwp_pkg::QUAD_PAGE_PROGRAM_INSTR_B:
         begin
            nxt_kind = fwp_pkg::OP_PROG;
            len_ok = fr_in.len >= fwp_pkg::LEN_WITH_DATA;
            blocked = prot_hit(sr_ff.block_protect, fr_in.addr[fwp_pkg::BLK_MSB:fwp_pkg::BLK_LSB]);
         end
         fwp_pkg::SECTOR_ERASE_INSTR_A, fwp_pkg::SECTOR_ERASE_INSTR_B,
         fwp_pkg::BLOCK_ERASE_SMALL_INSTR, fwp_pkg::BLOCK_ERASE_LARGE_INSTR:
         begin
            nxt_kind = fwp_pkg::OP_ERASE;
            len_ok = fr_in.len >= fwp_pkg::LEN_ADDRESSED;
            blocked = prot_hit(sr_ff.block_protect, fr_in.addr[fwp_pkg::BLK_MSB:fwp_pkg::BLK_LSB]);
         end
         fwp_pkg::CHIP_ERASE_INSTR_A, fwp_pkg::CHIP_ERASE_INSTR_B:
         begin
            nxt_kind = fwp_pkg::OP_CHIP;
            len_ok = fr_in.len >= fwp_pkg::LEN_OPCODE;
            blocked = sr_ff.block_protect != 4'h0;
         end
         fwp_pkg::STATUS_WRITE_INSTR:
         begin
            nxt_kind = fwp_pkg::OP_SREG;
            len_ok = fr_in.len >= fwp_pkg::LEN_REG_WRITE;
            blocked = sr_locked;
         end
         fwp_pkg::FUNCTION_WRITE_INSTR:
         begin
            nxt_kind = fwp_pkg::OP_FREG;
            len_ok = fr_in.len >= fwp_pkg::LEN_REG_WRITE;
         end
         fwp_pkg::READ_PARAMS_NV_WRITE_INSTR, fwp_pkg::EXT_READ_PARAMS_NV_WRITE_INSTR,
         fwp_pkg::AUTOBOOT_WRITE_INSTR:
         begin
            nxt_kind = fwp_pkg::OP_NVREG;
            len_ok = fr_in.len >= fwp_pkg::LEN_REG_WRITE;
         end
         fwp_pkg::INFO_ROW_ERASE_INSTR:
         begin
            nxt_kind = fwp_pkg::OP_IR_ERASE;
            len_ok = fr_in.len >= fwp_pkg::LEN_ADDRESSED;
         end
         fwp_pkg::INFO_ROW_PROGRAM_INSTR:
         begin
            nxt_kind = fwp_pkg::OP_IR_PROG;
            len_ok = fr_in.len >= fwp_pkg::LEN_WITH_DATA;
            blocked = fr_ff.info_row_lock[fr_in.addr[fwp_pkg::IR_ROW_MSB:fwp_pkg::IR_ROW_LSB]];
         end
         fwp_pkg::SUSPEND_INSTR:
            do_susp = 1'b1;
         fwp_pkg::RESUME_INSTR:
            do_resume = 1'b1;
         default:
            nxt_kind = fwp_pkg::OP_NONE;
      endcase
   end

   // Busy device ignores everything but suspend; suspended device takes no new write
   assign go_write = frame_done && st_ff == fwp_pkg::ST_IDLE && nxt_kind != fwp_pkg::OP_NONE;
   assign accept = go_write && sr_ff.write_enable_latch && len_ok && !blocked;
   assign refuse = go_write && !accept;
   assign finish = st_ff == fwp_pkg::ST_BUSY && busy_cnt_ff == 8'h01;

   // ==========================================================
   // Operation sequencer
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= fwp_pkg::ST_IDLE;
         kind_ff <= fwp_pkg::OP_NONE;
         busy_cnt_ff <= 8'h00;
      end
      else
      begin
         unique case (st_ff)
            fwp_pkg::ST_IDLE:
               if (accept)
               begin
                  st_ff <= fwp_pkg::ST_BUSY;
                  kind_ff <= nxt_kind;
                  busy_cnt_ff <= fwp_pkg::NV_BUSY_CYC;
               end
            fwp_pkg::ST_BUSY:
               if (finish)
               begin
                  st_ff <= fwp_pkg::ST_IDLE;
                  kind_ff <= fwp_pkg::OP_NONE;
                  busy_cnt_ff <= 8'h00;
               end
               else
               begin
                  busy_cnt_ff <= busy_cnt_ff - 8'h01;
                  if (frame_done && do_susp &&
                      (kind_ff == fwp_pkg::OP_PROG || kind_ff == fwp_pkg::OP_ERASE))
                     st_ff <= fwp_pkg::ST_SUSP;
               end
            fwp_pkg::ST_SUSP:
               if (frame_done && do_resume)
                  st_ff <= fwp_pkg::ST_BUSY;
         endcase
      end
   end

   // ==========================================================
   // Status register
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         sr_ff <= fwp_pkg::STATUS_RESET;
      else
      begin
         sr_ff.write_in_progress <= (st_ff == fwp_pkg::ST_IDLE && accept) ||
                                    (st_ff == fwp_pkg::ST_BUSY && !finish && !(frame_done && do_susp &&
                                    (kind_ff == fwp_pkg::OP_PROG || kind_ff == fwp_pkg::OP_ERASE))) ||
                                    (st_ff == fwp_pkg::ST_SUSP && frame_done && do_resume);
         if (finish)
            sr_ff.write_enable_latch <= 1'b0;
         else if (frame_done && st_ff != fwp_pkg::ST_BUSY && do_write_enable_instr)
            sr_ff.write_enable_latch <= 1'b1;
         else if (frame_done && st_ff != fwp_pkg::ST_BUSY && do_write_disable_instr)
            sr_ff.write_enable_latch <= 1'b0;
         if (accept && nxt_kind == fwp_pkg::OP_SREG)
         begin
            sr_ff.status_write_disable <= fr_in.byte1[7];
            sr_ff.quad_enable <= fr_in.byte1[6];
            sr_ff.block_protect <= fr_in.byte1[5:2];
         end
      end
   end

   // ==========================================================
   // Function register
   logic [1:0] strap_cnt_ff;

   // Strap is taken once, a few cycles after reset release, never by the reset itself
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         strap_cnt_ff <= 2'h0;
      else if (strap_cnt_ff != fwp_pkg::STRAP_WAIT)
         strap_cnt_ff <= strap_cnt_ff + 2'h1;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         fr_ff <= fwp_pkg::FUNCTION_RESET;
      else
      begin
         fr_ff.reserved <= 1'b0;
         // One-time bits only ever gain ones
         fr_ff.reset_pin_disable <= fr_ff.reset_pin_disable |
                                    (strap_cnt_ff == 2'h2 && strap_sync) |
                                    (accept && nxt_kind == fwp_pkg::OP_FREG && fr_in.byte1[0]);
         if (accept && nxt_kind == fwp_pkg::OP_FREG)
            fr_ff.info_row_lock <= fr_ff.info_row_lock | fr_in.byte1[7:4];
         if (st_ff == fwp_pkg::ST_BUSY && !finish && frame_done && do_susp)
         begin
            fr_ff.program_suspended_flag <= kind_ff == fwp_pkg::OP_PROG;
            fr_ff.erase_suspended_flag <= kind_ff == fwp_pkg::OP_ERASE;
         end
         else if (st_ff == fwp_pkg::ST_SUSP && frame_done && do_resume)
         begin
            fr_ff.program_suspended_flag <= 1'b0;
            fr_ff.erase_suspended_flag <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Array request and pin function outputs
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         op_start <= 1'b0;
         op_kind <= fwp_pkg::OP_NONE;
         op_addr <= 24'h00_0000;
         op_data <= 8'h00;
         op_done <= 1'b0;
         refused <= 1'b0;
      end
      else
      begin
         op_start <= accept;
         op_done <= finish;
         refused <= refuse;
         if (accept)
         begin
            op_kind <= nxt_kind;
            op_addr <= fr_in.addr;
            op_data <= nxt_kind == fwp_pkg::OP_PROG || nxt_kind == fwp_pkg::OP_IR_PROG ?
                       fr_in.data : fr_in.byte1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         quad_io_mode <= 1'b0;
         hold_active <= 1'b0;
         device_reset <= 1'b0;
      end
      else
      begin
         quad_io_mode <= sr_ff.quad_enable;
         hold_active <= !sr_ff.quad_enable && !fr_ff.reset_pin_disable && !hold_sync;
         device_reset <= fr_ff.reset_pin_disable ? (!sr_ff.quad_enable && !hold_sync) : !drst_sync;
      end
   end

   assign status_q = sr_ff;
   assign function_q = fr_ff;

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_susp_in(fwp_pkg::fwp_op_e k);
      st_ff == fwp_pkg::ST_BUSY && !finish && frame_done && do_susp && kind_ff == k;
   endsequence

   sequence s_resume;
      st_ff == fwp_pkg::ST_SUSP && frame_done && do_resume;
   endsequence

   a_start_needs_latch: assert property (op_start |-> $past(sr_ff.write_enable_latch))
      else $error("operation started without write enable latch");
   a_chip_needs_clear: assert property (op_start && op_kind == fwp_pkg::OP_CHIP |->
      $past(sr_ff.block_protect) == 4'h0)
      else $error("chip erase started with protection set");
   a_no_protected_hit: assert property (op_start && (op_kind == fwp_pkg::OP_PROG ||
      op_kind == fwp_pkg::OP_ERASE) |-> !prot_hit($past(sr_ff.block_protect),
      op_addr[fwp_pkg::BLK_MSB:fwp_pkg::BLK_LSB]))
      else $error("program or erase started inside protected area");
   a_lock_holds_status: assert property (sr_locked && st_ff == fwp_pkg::ST_IDLE |=>
      $stable(sr_ff[7:2]))
      else $error("locked status bits changed");
   a_latch_ends_busy: assert property (finish |=> !sr_ff.write_enable_latch && op_done ##1
      !sr_ff.write_in_progress)
      else $error("latch or busy not cleared at operation end");
   a_otp_never_fall: assert property (fr_ff.reset_pin_disable || fr_ff.info_row_lock != 4'h0 |=>
      (fr_ff.reset_pin_disable >= $past(fr_ff.reset_pin_disable)) &&
      (($past(fr_ff.info_row_lock) & ~fr_ff.info_row_lock) == 4'h0))
      else $error("one-time bit returned to zero");
   a_prog_susp_flag: assert property (s_susp_in(fwp_pkg::OP_PROG) |=>
      fr_ff.program_suspended_flag && !sr_ff.write_in_progress)
      else $error("program suspend flag not set");
   a_erase_susp_flag: assert property (s_susp_in(fwp_pkg::OP_ERASE) |=>
      fr_ff.erase_suspended_flag ##1 fr_ff.erase_suspended_flag)
      else $error("erase suspend flag not set");
   a_resume_clears: assert property (s_resume |=> !fr_ff.program_suspended_flag &&
      !fr_ff.erase_suspended_flag && sr_ff.write_in_progress)
      else $error("suspend flags not cleared on resume");
   a_refuse_no_busy: assert property (refused |-> !sr_ff.write_in_progress && !op_start)
      else $error("refused operation raised busy");
   a_quad_frees_pins: assert property (sr_ff.quad_enable |=> quad_io_mode && !hold_active)
      else $error("quad mode left hold function active");
endmodule
`default_nettype wire

/* File: verilog/fwp_pkg.sv */
// Shared constants, layouts and types for the flash write-protect block
package fwp_pkg;

   // ==========================================================
   // Instruction codes
   localparam logic [7:0] WRITE_ENABLE_INSTR = 8'h06;
   localparam logic [7:0] WRITE_DISABLE_INSTR = 8'h04;
   localparam logic [7:0] STATUS_WRITE_INSTR = 8'h01;
   localparam logic [7:0] FUNCTION_WRITE_INSTR = 8'h42;
   localparam logic [7:0] PAGE_PROGRAM_INSTR = 8'h02;
   localparam logic [7:0] QUAD_PAGE_PROGRAM_INSTR_A = 8'h32;
   localparam logic [7:0] QUAD_PAGE_PROGRAM_INSTR_B = 8'h38;
   localparam logic [7:0] SECTOR_ERASE_INSTR_A = 8'hd7;
   localparam logic [7:0] SECTOR_ERASE_INSTR_B = 8'h20;
   localparam logic [7:0] BLOCK_ERASE_SMALL_INSTR = 8'h52;
   localparam logic [7:0] BLOCK_ERASE_LARGE_INSTR = 8'hd8;
   localparam logic [7:0] CHIP_ERASE_INSTR_A = 8'hc7;
   localparam logic [7:0] CHIP_ERASE_INSTR_B = 8'h60;
   localparam logic [7:0] READ_PARAMS_NV_WRITE_INSTR = 8'h65;
   localparam logic [7:0] EXT_READ_PARAMS_NV_WRITE_INSTR = 8'h85;
   localparam logic [7:0] INFO_ROW_ERASE_INSTR = 8'h64;
   localparam logic [7:0] INFO_ROW_PROGRAM_INSTR = 8'h62;
   localparam logic [7:0] AUTOBOOT_WRITE_INSTR = 8'h15;
   localparam logic [7:0] SUSPEND_INSTR = 8'h75;
   localparam logic [7:0] RESUME_INSTR = 8'h7a;

   // ==========================================================
   // Frame lengths in serial bits
   localparam logic [5:0] LEN_OPCODE = 6'h08;
   localparam logic [5:0] LEN_REG_WRITE = 6'h10;
   localparam logic [5:0] LEN_ADDRESSED = 6'h20;
   localparam logic [5:0] LEN_WITH_DATA = 6'h28;
   localparam logic [5:0] CNT_OPCODE_LAST = 6'h07;
   localparam logic [5:0] CNT_BYTE1_LAST = 6'h0f;
   localparam logic [5:0] CNT_ADDR_LAST = 6'h1f;
   localparam logic [5:0] CNT_DATA_LAST = 6'h27;

   // ==========================================================
   // Array geometry
   localparam int BLK_MSB = 21;
   localparam int BLK_LSB = 16;
   localparam int IR_ROW_MSB = 9;
   localparam int IR_ROW_LSB = 8;
   localparam logic [5:0] LAST_BLOCK = 6'h3f;

   // ==========================================================
   // Timing
   localparam int CORE_CLK_NS = 100;
   localparam int NV_BUSY_NS = 1000;
   localparam logic [7:0] NV_BUSY_CYC = 8'((NV_BUSY_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   // ==========================================================
   // Register layouts, bit 7 first
   typedef struct packed {
      logic status_write_disable;
      logic quad_enable;
      logic [3:0] block_protect;
      logic write_enable_latch;
      logic write_in_progress;
   } fwp_status_s;

   typedef struct packed {
      logic [3:0] info_row_lock;
      logic erase_suspended_flag;
      logic program_suspended_flag;
      logic reserved;
      logic reset_pin_disable;
   } fwp_function_s;

   localparam fwp_status_s STATUS_RESET = 8'h00;
   localparam fwp_function_s FUNCTION_RESET = 8'h00;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] byte1;
      logic [23:0] addr;
      logic [7:0] data;
      logic [5:0] len;
   } fwp_frame_s;

   typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_SUSP} fwp_state_e;

   typedef enum logic [3:0] {
      OP_NONE, OP_PROG, OP_ERASE, OP_CHIP, OP_SREG, OP_FREG, OP_NVREG, OP_IR_ERASE, OP_IR_PROG
   } fwp_op_e;

endpackage

/* File: verilog/fwp_sync.sv */
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module fwp_sync #(
   parameter int WIDTH = 5
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;

   // Resets to all ones so the active-low pins read as inactive high levels
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_ff <= '1;
         sync_out <= '1;
      end
      else
      begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule
`default_nettype wire
